// >>> core/aout_frame_pkg.sv
// constants and register layout for the audio out serial frame builder
// Overview of operation
// - a frame lasts the frame length divider plus one bit clocks
// - each frame may carry two 16-bit control fields, each with its own enable
// - an enabled control field sends its stored word from its start position
// - both control enables are zero after reset
// - both control start positions are zero after reset
// - control fields follow the same bit order as samples
// - writing a control pair fills the holding buffer and sets pending
// - pending clears once the pair moves into the transmit shadow
// - pending low means ready, high means not ready; it resets low
// - without a new pair the old control words repeat every frame
// - no interrupt exists; progress is seen only by polling pending
// - same start position: left, right, first control, second control
// - a later-starting field cuts off the rest of an earlier field
// - uncovered frame bits are sent as zero
// - frames keep running while transmission is disabled
// - the last control pair written appears in the next frame
// - msb first: top bit at start position, down to the stop bit index
// - pulse mode drives word select for one bit clock per frame
package aout_frame_pkg;
	localparam int POS_W = 9;
	localparam int HALF_W = 8;
	// register byte offsets
	localparam logic [4:0] OFS_CONTROL = 5'h00;
	localparam logic [4:0] OFS_WORD_PAIR = 5'h04;
	localparam logic [4:0] OFS_POSITIONS = 5'h08;
	localparam logic [4:0] OFS_STATE = 5'h0c;
	localparam logic [4:0] OFS_TIMING = 5'h10;
	// audio_out_control fields
	localparam int CTL_TRANSMIT_ENABLE = 0;
	localparam int CTL_BIT_ORDER = 1;
	localparam int CTL_CLOCK_EDGE = 2;
	localparam int CTL_WORD_SELECT_PULSE_MODE = 3;
	localparam int CTL_POLARITY = 4;
	localparam int CTL_STEREO = 5;
	localparam int CTL_WIDE = 6;
	localparam int CTL_FIRST_EN = 7;
	localparam int CTL_SECOND_EN = 8;
	localparam int CTL_STOP_LSB = 9;
	localparam int CTL_LEFT_LSB = 14;
	localparam int CTL_RIGHT_LSB = 23;
	// codec_word_pair and codec_field_positions fields
	localparam int PAIR_SECOND_LSB = 16;
	localparam int POS_FIRST_LSB = 0;
	localparam int POS_SECOND_LSB = 16;
	// timing register fields
	localparam int TIM_DIV_LSB = 0;
	localparam int TIM_HALF_LSB = 16;
	// audio_out_state fields
	localparam int ST_PENDING = 0;
	localparam int ST_WORD_SELECT = 1;
	localparam int ST_COUNT_LSB = 16;
	// reset values
	localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
	localparam logic [31:0] RST_POSITIONS = 32'h0000_0000;
	localparam logic [POS_W-1:0] RST_DIVIDER = 9'h03f;
	localparam logic [HALF_W-1:0] RST_HALF = 8'h01;
	localparam logic [15:0] CTRL_MSB = 16'h000f;
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ANSWER = 1'b1
	} bus_state_t;
endpackage : aout_frame_pkg

// >>> core/aout_frame_codec.sv
// audio out serial frame builder with codec control fields and avalon slave
`timescale 1ns/1ps
module aout_frame_codec
	import aout_frame_pkg::*;
(
	input wire logic clk, // 25 mhz system clock
	input wire logic rst, // async reset, active high
	input wire logic [4:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [3:0] avs_byteenable, // write byte lanes
	input wire logic [31:0] avs_writedata, // write data
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // low marks the accepting edge
	input wire logic [31:0] left_sample, // left sample, caught at frame start
	input wire logic [31:0] right_sample, // right sample, caught at frame start
	output logic sample_strobe, // one-cycle pulse when samples are caught
	output logic bit_clock_line, // serial bit clock
	output logic word_select_line, // serial word select
	output logic serial_data_lines // serial data
);
	logic [31:0] ctl_r, ctl_nxt;
	logic [31:0] pos_r, pos_nxt;
	logic [POS_W-1:0] div_r, div_nxt;
	logic [HALF_W-1:0] half_r, half_nxt;
	logic [31:0] buf_r, buf_nxt;
	logic [31:0] shadow_r, shadow_nxt;
	logic pending_r, pending_nxt;
	logic [31:0] left_r, left_nxt;
	logic [31:0] right_r, right_nxt;
	logic [HALF_W-1:0] hcnt_r, hcnt_nxt;
	logic [POS_W-1:0] cnt_r, cnt_nxt;
	logic sck_r, sck_nxt;
	logic ws_r, ws_nxt;
	logic sd_r, sd_nxt;
	logic strobe_r, strobe_nxt;
	bus_state_t bus_r, bus_nxt;
	logic wait_r, wait_nxt;
	logic [31:0] rdata_r, rdata_nxt;

	// control field aliases
	logic order_lsb, wide, stereo;
	logic [4:0] stop_idx;
	logic [POS_W-1:0] start [4];
	logic [3:0] present;
	assign order_lsb = ctl_r[CTL_BIT_ORDER];
	assign wide = ctl_r[CTL_WIDE];
	assign stereo = ctl_r[CTL_STEREO];
	assign stop_idx = wide ? ctl_r[CTL_STOP_LSB +: 5] : {1'b0, ctl_r[CTL_STOP_LSB +: 4]};
	assign start[0] = ctl_r[CTL_LEFT_LSB +: POS_W];
	assign start[1] = ctl_r[CTL_RIGHT_LSB +: POS_W];
	assign start[2] = pos_r[POS_FIRST_LSB +: POS_W];
	assign start[3] = pos_r[POS_SECOND_LSB +: POS_W];
	assign present = {ctl_r[CTL_SECOND_EN], ctl_r[CTL_FIRST_EN], 2'b11};

	// writable register image with byte lanes applied
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old & ~m) | (wd & m);
	endfunction : merge

	always_comb begin
		logic tick, edge_is_fall, change, wrap, first_half;
		logic [POS_W-1:0] n;
		logic [POS_W-1:0] best_start;
		logic [2:0] best;
		logic [9:0] off;
		logic [9:0] msb;
		logic [9:0] idx;
		logic [31:0] lsrc, rsrc, sh;
		logic [31:0] wimg;
		logic acc, hit;
		tick = 1'b0;
		edge_is_fall = 1'b0;
		change = 1'b0;
		wrap = 1'b0;
		first_half = 1'b0;
		n = '0;
		best_start = '0;
		best = 3'd4;
		off = '0;
		msb = '0;
		idx = '0;
		lsrc = '0;
		rsrc = '0;
		sh = '0;
		wimg = '0;
		acc = 1'b0;
		hit = 1'b0;
		ctl_nxt = ctl_r;
		pos_nxt = pos_r;
		div_nxt = div_r;
		half_nxt = half_r;
		buf_nxt = buf_r;
		shadow_nxt = shadow_r;
		pending_nxt = pending_r;
		left_nxt = left_r;
		right_nxt = right_r;
		hcnt_nxt = hcnt_r;
		cnt_nxt = cnt_r;
		sck_nxt = sck_r;
		ws_nxt = ws_r;
		sd_nxt = sd_r;
		strobe_nxt = 1'b0;
		bus_nxt = bus_r;
		wait_nxt = wait_r;
		rdata_nxt = rdata_r;

		// bit clock divider, free running so frames never stop
		if (hcnt_r >= half_r) begin
			hcnt_nxt = '0;
			tick = 1'b1;
			sck_nxt = ~sck_r;
		end else begin
			hcnt_nxt = hcnt_r + 1'b1;
		end
		edge_is_fall = sck_r;
		change = tick && (edge_is_fall ^ ctl_r[CTL_CLOCK_EDGE]);

		// next frame bit position and frame wrap
		wrap = (cnt_r >= div_r);
		n = wrap ? '0 : cnt_r + 1'b1;

		// data seen by the bit about to go out; a wrap uses the fresh values
		lsrc = (change && wrap) ? left_sample : left_r;
		rsrc = (change && wrap) ? (stereo ? right_sample : left_sample) : right_r;
		if (!ctl_r[CTL_TRANSMIT_ENABLE]) begin
			lsrc = '0;
			rsrc = '0;
		end
		sh = (change && wrap && pending_r) ? buf_r : shadow_r;

		// latest-starting field wins; ties keep the earlier, higher-priority one
		for (int i = 0; i < 4; i++) begin
			if (present[i] && start[i] <= n) begin
				if (best == 3'd4 || start[i] > best_start) begin
					best = 3'(i);
					best_start = start[i];
				end
			end
		end
		off = 10'(n - best_start);
		case (best)
			3'd0, 3'd1: begin
				msb = wide ? 10'd31 : 10'd15;
				if (order_lsb) begin
					idx = 10'(stop_idx) + off;
					hit = (idx <= msb);
				end else begin
					idx = msb - off;
					hit = (off <= msb - 10'(stop_idx));
				end
				if (hit) begin
					sd_nxt = (best == 3'd0) ? lsrc[idx[4:0]] : rsrc[idx[4:0]];
				end
			end
			3'd2, 3'd3: begin
				idx = order_lsb ? off : 10'(CTRL_MSB) - off;
				hit = (off <= 10'(CTRL_MSB));
				if (hit) begin
					sd_nxt = (best == 3'd2) ? sh[idx[3:0]] : sh[5'(PAIR_SECOND_LSB) + 5'(idx[3:0])];
				end
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		if (!hit) begin
			sd_nxt = 1'b0;
		end

		// word select: half duty or one bit per frame
		first_half = ({1'b0, n} <= ({1'b0, div_r} >> 1));
		if (ctl_r[CTL_WORD_SELECT_PULSE_MODE]) begin
			ws_nxt = ctl_r[CTL_POLARITY] ? (n == '0) : (n != '0);
		end else begin
			ws_nxt = ctl_r[CTL_POLARITY] ? first_half : ~first_half;
		end

		if (change) begin
			cnt_nxt = n;
			if (wrap) begin
				left_nxt = lsrc;
				right_nxt = rsrc;
				strobe_nxt = 1'b1;
				if (pending_r) begin
					shadow_nxt = buf_r;
					pending_nxt = 1'b0;
				end
			end
		end else begin
			sd_nxt = sd_r;
			ws_nxt = ws_r;
		end

		// avalon slave: one wait cycle, then accept
		acc = 1'b0;
		case (bus_r)
			BUS_IDLE: begin
				if (avs_read || avs_write) begin
					bus_nxt = BUS_ANSWER;
					wait_nxt = 1'b0;
					rdata_nxt = '0;
					if (avs_address == OFS_CONTROL) begin
						rdata_nxt = ctl_r;
					end else if (avs_address == OFS_WORD_PAIR) begin
						rdata_nxt = buf_r;
					end else if (avs_address == OFS_POSITIONS) begin
						rdata_nxt = pos_r;
					end else if (avs_address == OFS_STATE) begin
						rdata_nxt[ST_PENDING] = pending_r;
						rdata_nxt[ST_WORD_SELECT] = ws_r;
						rdata_nxt[ST_COUNT_LSB +: POS_W] = cnt_r;
					end else if (avs_address == OFS_TIMING) begin
						rdata_nxt[TIM_DIV_LSB +: POS_W] = div_r;
						rdata_nxt[TIM_HALF_LSB +: HALF_W] = half_r;
					end
				end
			end
			BUS_ANSWER: begin
				acc = 1'b1;
				bus_nxt = BUS_IDLE;
				wait_nxt = 1'b1;
			end
			default: begin
				bus_nxt = BUS_IDLE;
				wait_nxt = 1'b1;
			end
		endcase
		if (acc && avs_write) begin
			if (avs_address == OFS_CONTROL) begin
				ctl_nxt = merge(ctl_r, avs_writedata, avs_byteenable);
			end else if (avs_address == OFS_WORD_PAIR) begin
				buf_nxt = merge(buf_r, avs_writedata, avs_byteenable);
				pending_nxt = 1'b1;
			end else if (avs_address == OFS_POSITIONS) begin
				wimg = merge(pos_r, avs_writedata, avs_byteenable);
				pos_nxt = '0;
				pos_nxt[POS_FIRST_LSB +: POS_W] = wimg[POS_FIRST_LSB +: POS_W];
				pos_nxt[POS_SECOND_LSB +: POS_W] = wimg[POS_SECOND_LSB +: POS_W];
			end else if (avs_address == OFS_TIMING) begin
				wimg = merge({8'h00, half_r, 7'h00, div_r}, avs_writedata, avs_byteenable);
				div_nxt = wimg[TIM_DIV_LSB +: POS_W];
				half_nxt = wimg[TIM_HALF_LSB +: HALF_W];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctl_r <= RST_CONTROL;
			pos_r <= RST_POSITIONS;
			div_r <= RST_DIVIDER;
			half_r <= RST_HALF;
			buf_r <= '0;
			shadow_r <= '0;
			pending_r <= 1'b0;
			left_r <= '0;
			right_r <= '0;
			hcnt_r <= '0;
			cnt_r <= '0;
			sck_r <= 1'b0;
			ws_r <= 1'b0;
			sd_r <= 1'b0;
			strobe_r <= 1'b0;
			bus_r <= BUS_IDLE;
			wait_r <= 1'b1;
			rdata_r <= '0;
		end else begin
			ctl_r <= ctl_nxt;
			pos_r <= pos_nxt;
			div_r <= div_nxt;
			half_r <= half_nxt;
			buf_r <= buf_nxt;
			shadow_r <= shadow_nxt;
			pending_r <= pending_nxt;
			left_r <= left_nxt;
			right_r <= right_nxt;
			hcnt_r <= hcnt_nxt;
			cnt_r <= cnt_nxt;
			sck_r <= sck_nxt;
			ws_r <= ws_nxt;
			sd_r <= sd_nxt;
			strobe_r <= strobe_nxt;
			bus_r <= bus_nxt;
			wait_r <= wait_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign sample_strobe = strobe_r;
	assign bit_clock_line = sck_r;
	assign word_select_line = ws_r;
	assign serial_data_lines = sd_r;
endmodule : aout_frame_codec

// >>> dv/aout_frame_chk.sv
// port assertions for the audio out frame builder
`timescale 1ns/1ps
module aout_frame_chk (
	input wire logic clk, // system clock
	input wire logic rst, // async reset
	input wire logic [4:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_readdata, // read data
	input wire logic avs_waitrequest, // bus stall
	input wire logic sample_strobe, // samples caught
	input wire logic bit_clock_line, // bit clock
	input wire logic word_select_line, // word select
	input wire logic serial_data_lines // serial data
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_idle_wait: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
		else $error("waitrequest low without request");
	a_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address > 5'h10
		|=> avs_readdata == 32'h0) else $error("unmapped read not zero");
	a_sd_on_fall: assert property ($changed(serial_data_lines) |-> $fell(bit_clock_line))
		else $error("data moved off the falling edge");
	a_ws_on_fall: assert property ($changed(word_select_line) |-> $fell(bit_clock_line))
		else $error("word select moved off the falling edge");
	a_strobe_once: assert property (sample_strobe |=> !sample_strobe [*8])
		else $error("sample strobe repeats");
	a_strobe_bit_zero: assert property (sample_strobe |-> !bit_clock_line && !word_select_line)
		else $error("sample strobe outside frame bit zero");
	a_sck_half: assert property ($rose(bit_clock_line) |=> bit_clock_line ##1 !bit_clock_line)
		else $error("bit clock high time wrong");
	c_strobe: cover property (sample_strobe);
	c_write: cover property (avs_write && !avs_waitrequest);
	c_frame: cover property ($fell(word_select_line));
endmodule : aout_frame_chk

// >>> dv/codec_rx_model.sv
// behavioural codec receiver on the serial link
`timescale 1ns/1ps
module codec_rx_model (
	input wire logic bit_clock_line, // bit clock
	input wire logic word_select_line, // word select
	input wire logic serial_data_lines, // serial data
	output logic [63:0] frame = '0, // last whole frame, index is frame bit
	output int nbits = 0, // length of that frame
	output int low_bits = 0, // bits with word select low
	output int frames = 0 // frames seen
);
	logic [63:0] cur = '0;
	logic ws_q = 1'b0;
	int cnt = 0;
	int lows = 0;
	// samples on the rising edge, so data must settle after the fall
	always @(posedge bit_clock_line) begin
		if (ws_q && !word_select_line) begin
			frame <= cur;
			nbits <= cnt;
			low_bits <= lows;
			frames <= frames + 1;
			cur <= {63'h0, serial_data_lines};
			cnt <= 1;
			lows <= 1;
		end else begin
			if (cnt < 64) cur[cnt] <= serial_data_lines;
			cnt <= cnt + 1;
			lows <= lows + int'(!word_select_line);
		end
		ws_q <= word_select_line;
	end
endmodule : codec_rx_model

// >>> dv/testbench.sv
// self-checking bench for the audio out frame builder
`timescale 1ns/1ps
module testbench;
	import aout_frame_pkg::*;
	logic clk, rst, avs_read, avs_write, avs_waitrequest, sample_strobe;
	logic bit_clock_line, word_select_line, serial_data_lines;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, left_sample, right_sample, q, c, p, w;
	logic [63:0] frame;
	int nbits, low_bits, frames, mismatches, total_checks, seed, dv, n, f0;
	aout_frame_codec dut (.clk, .rst, .avs_address, .avs_read, .avs_write,
		.avs_byteenable(4'hf), .avs_writedata, .avs_readdata, .avs_waitrequest,
		.left_sample, .right_sample, .sample_strobe, .bit_clock_line,
		.word_select_line, .serial_data_lines);
	codec_rx_model rx (.bit_clock_line, .word_select_line, .serial_data_lines,
		.frame, .nbits, .low_bits, .frames);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task chk(input string nm, input logic [63:0] e, input logic [63:0] s);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// request held until waitrequest is seen low at a rising edge
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		n = 0;
		// waitrequest is read at the rising edge, before the slave updates it
		do @(posedge clk); while (avs_waitrequest !== 1'b0 && ++n < 50);
		if (n >= 50) mismatches++;
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task frames_go(input int k);
		f0 = frames;
		n = 0;
		while (frames < f0 + k && n++ < 3000) @(posedge clk);
		if (frames < f0 + k) mismatches++;
	endtask : frames_go
	function automatic logic [63:0] exp_frame();
		int st[4], ln[4], b, top, stop;
		logic [31:0] v[4];
		logic [63:0] f;
		top = c[6] ? 31 : 15;
		stop = c[6] ? int'(c[13:9]) : int'(c[12:9]);
		v = '{left_sample, c[5] ? right_sample : left_sample, w[15:0], w[31:16]};
		st = '{c[22:14], c[31:23], p[8:0], p[24:16]};
		ln = '{top - stop + 1, top - stop + 1, c[7] ? 16 : 0, c[8] ? 16 : 0};
		f = '0;
		for (int i = 0; i <= dv; i++) begin
			b = -1;
			for (int k = 0; k < 4; k++)
				if (ln[k] > 0 && st[k] <= i && (b < 0 || st[k] > st[b])) b = k;
			if (b >= 0 && i - st[b] < ln[b])
				f[i] = c[1] ? v[b][(b < 2 ? stop : 0) + i - st[b]] : v[b][(b < 2 ? top : 15) - i + st[b]];
		end
		return f;
	endfunction : exp_frame
	task report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		report_and_stop();
	end
	initial begin
		seed = 48822;
		rst = 1'b1;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		{left_sample, right_sample} = '0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		bus(0, OFS_CONTROL, 0);
		chk("control", RST_CONTROL, q);
		bus(0, OFS_POSITIONS, 0);
		chk("positions", RST_POSITIONS, q);
		bus(0, OFS_STATE, 0);
		chk("pending", 0, q[ST_PENDING]);
		bus(0, 5'h14, 0);
		chk("unmapped", 0, q);
		frames_go(2);
		chk("idle length", 64, nbits);
		for (int i = 0; i < 8; i++) begin
			dv = 36 + {$random(seed)} % 28;
			c = $random(seed);
			c[6:0] = {c[6], c[5], 1'b0, c[3], 1'b0, c[1], 1'b1};
			c[22:14] = {3'h0, c[19:14]};
			c[31:23] = {3'h0, c[28:23]};
			p = $random(seed) & 32'h003f_003f;
			if (i == 0) begin
				c[31:14] = '0;
				p = '0;
			end
			if (i == 1) begin
				c[31:14] = {9'h020, 9'h000};
				c[8:7] = 2'b11;
				p = 32'h0030_0010;
			end
			w = $random(seed);
			left_sample <= $random(seed);
			right_sample <= $random(seed);
			bus(1, OFS_TIMING, 32'h0001_0000 | dv);
			bus(1, OFS_CONTROL, c);
			bus(1, OFS_POSITIONS, p);
			do bus(0, OFS_STATE, 0); while (q[ST_PENDING] !== 1'b0);
			frames_go(1);
			bus(1, OFS_WORD_PAIR, w);
			bus(0, OFS_STATE, 0);
			chk("pending set", 1, q[ST_PENDING]);
			frames_go(1);
			bus(0, OFS_STATE, 0);
			chk("pending clear", 0, q[ST_PENDING]);
			frames_go(1);
			chk("first frame", exp_frame(), frame);
			frames_go(1);
			chk("repeat frame", exp_frame(), frame);
			chk("length", dv + 1, nbits);
			chk("ws low bits", c[3] ? 1 : dv / 2 + 1, low_bits);
		end
		report_and_stop();
	end
endmodule : testbench
bind aout_frame_codec aout_frame_chk chk (.clk, .rst, .avs_address, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .sample_strobe, .bit_clock_line, .word_select_line,
	.serial_data_lines);
